// ---- logic/rsc_coef_mapper.sv ----
/*
  Coefficient address mapper: turns a channel's tap index into a coefficient
  memory address according to the filter count and the channel's filter select.
  Assumes a tap request strobe from the multiply sequencer.
*/
`timescale 1ns/1ns
module rsc_coef_mapper #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rstSync_n,
  input wire logic tapReq,
  input wire logic [1:0] tapChan,
  input wire logic [ADDR_W-1:0] tapIdx,
  input wire logic [1:0] filterCountCode,
  input wire logic [7:0] filterSelect,
  output logic coefValid,
  output logic [ADDR_W-1:0] coefAddr
);

  logic [1:0] sel;
  logic [ADDR_W-1:0] nxt_addr;

  // ********************************************************************
  // Interleaved partition of the coefficient memory
  // ********************************************************************
  always_comb begin
    sel = filterSelect[2*tapChan +: 2];
    case (filterCountCode)
      2'h0: nxt_addr = tapIdx;
      2'h1: nxt_addr = {tapIdx[ADDR_W-2:0], sel[0]};
      2'h3: nxt_addr = {tapIdx[ADDR_W-3:0], sel};
      default: nxt_addr = tapIdx;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      coefValid <= 1'b0;
      coefAddr <= '0;
    end else begin
      coefValid <= tapReq;
      if (tapReq) begin
        coefAddr <= nxt_addr;
      end
    end
  end

endmodule : rsc_coef_mapper

// ---- logic/rsc_output_shaper.sv ----
/*
  Output shaper: final gain shift, rounding into the top bits of a 24-bit word,
  and optional two-bit tag insertion.
  Assumes a registered result stream with a valid strobe and a channel number.
*/
`timescale 1ns/1ns
module rsc_output_shaper #(
  parameter int IN_W = 32
) (
  input wire logic core_clk,
  input wire logic rstSync_n,
  input wire logic inValid,
  input wire logic [1:0] inChan,
  input wire logic signed [IN_W-1:0] inData,
  input wire logic [3:0] gainShift,
  input wire logic [1:0] roundCode,
  input wire logic tagMode,
  input wire logic [7:0] tagLow,
  output logic outValid,
  output logic [1:0] outChan,
  output logic [rsc_pkg::OUT_W-1:0] outData
);

  localparam int EXT_W = rsc_pkg::OUT_W + 1;

  logic signed [IN_W+15:0] shifted;
  logic [EXT_W-1:0] window;
  logic [EXT_W-1:0] halfLsb;
  logic [EXT_W-1:0] rounded;
  logic [4:0] keep;
  logic [rsc_pkg::OUT_W-1:0] nxt_word;

  // ********************************************************************
  // Shift, round and tag
  // ********************************************************************
  always_comb begin
    shifted = {{16{inData[IN_W-1]}}, inData} <<< gainShift;
    window = shifted[IN_W-1 -: EXT_W];
    keep = rsc_pkg::keep_bits(roundCode, tagMode);
    // Half of the kept LSB sits one place below the round point.
    halfLsb = EXT_W'(1) << (5'(rsc_pkg::OUT_W) - keep);
    rounded = window + halfLsb;
    // Bits below the round point are passed on as they fall, not cleared.
    nxt_word = rounded[EXT_W-1:1];
    if (tagMode) begin
      nxt_word[1:0] = tagLow[2*inChan +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      outValid <= 1'b0;
      outChan <= 2'h0;
      outData <= '0;
    end else begin
      outValid <= inValid;
      if (inValid) begin
        outChan <= inChan;
        outData <= nxt_word;
      end
    end
  end

endmodule : rsc_output_shaper

// ---- logic/rsc_pkg.sv ----
/*
  Package for the resampler control block: register indices, field positions,
  reset values and the shared width helpers.
  Assumes nothing of its surroundings; the other files that use it refer to it by rsc_pkg::name.
*/
package rsc_pkg;

  // ********************************************************************
  // Register indices on the resampler control page
  // ********************************************************************
  localparam logic [5:0] IDX_OUT_CHAN_CFG = 6'h10;
  localparam logic [5:0] IDX_MULT_CNT_CFG = 6'h11;
  localparam logic [5:0] IDX_FILTER_ASSIGN = 6'h12;
  localparam logic [5:0] IDX_GAIN_ROUND = 6'h13;
  localparam logic [5:0] IDX_CHAN_ROUTING = 6'h14;
  localparam logic [5:0] IDX_CHAN_SUMMING = 6'h15;
  localparam logic [5:0] IDX_CLK_DIVIDER = 6'h16;
  localparam logic [5:0] IDX_RATIO_ASSIGN = 6'h17;
  localparam logic [5:0] IDX_UNUSED_FIRST = 6'h18;
  localparam logic [5:0] IDX_UNUSED_LAST = 6'h1f;
  localparam int NUM_REGS = 8;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [7:0] RST_OUT_CHAN_CFG = 8'h23;
  localparam logic [7:0] RST_MULT_CNT_CFG = 8'h0e;
  localparam logic [7:0] RST_FILTER_ASSIGN = 8'h00;
  localparam logic [7:0] RST_GAIN_ROUND = 8'h34;
  localparam logic [7:0] RST_CHAN_ROUTING = 8'he4;
  localparam logic [7:0] RST_CHAN_SUMMING = 8'h70;
  localparam logic [7:0] RST_CLK_DIVIDER = 8'h00;
  localparam logic [7:0] RST_RATIO_ASSIGN = 8'h00;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int OCC_CHAN_LSB = 0;
  localparam int OCC_FILT_LSB = 2;
  localparam int OCC_SYNC_LSB = 4;
  localparam int MCC_COUNT_LSB = 0;
  localparam int MCC_ASYM_BIT = 6;
  localparam int GSR_SHIFT_LSB = 0;
  localparam int GSR_ROUND_LSB = 4;
  localparam int GSR_TAG_BIT = 6;

  // ********************************************************************
  // Data widths and rounding codes
  // ********************************************************************
  localparam int OUT_W = 24;
  localparam logic [1:0] ROUND_12 = 2'h0;
  localparam logic [1:0] ROUND_16 = 2'h1;
  localparam logic [1:0] ROUND_20 = 2'h2;
  localparam logic [1:0] ROUND_24 = 2'h3;
  localparam logic [4:0] KEEP_TAGGED_TOP = 5'h16;

  // Number of kept result bits for a rounding code and tag mode.
  function automatic logic [4:0] keep_bits(input logic [1:0] roundCode, input logic tagMode);
    logic [4:0] k;
    k = 5'h0;
    case (roundCode)
      ROUND_12: k = 5'h0c;
      ROUND_16: k = 5'h10;
      ROUND_20: k = 5'h14;
      default: k = tagMode ? KEEP_TAGGED_TOP : 5'h18;
    endcase
    return k;
  endfunction : keep_bits

endpackage : rsc_pkg

// ---- logic/rsc_resampler_ctrl.sv ----
/*
  Resampler control block: the eight configuration registers of the resampler
  page behind an AHB-Lite slave, the sync-driven clear of the per-channel delay
  accumulators, the coefficient address mapper and the output shaper.
  Assumes a single AHB-Lite master, word transfers only, and sync and datapath
  inputs synchronous to core_clk.
*/
`timescale 1ns/1ns
module rsc_resampler_ctrl #(
  parameter int IN_W = 32,
  parameter int DLY_W = 16,
  parameter int COEF_ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] syncSources,
  input wire logic [3:0] dlyAdvance,
  input wire logic [DLY_W-1:0] dlyStep,
  output logic [4*DLY_W-1:0] delayAccum,
  output logic syncClear,
  input wire logic tapReq,
  input wire logic [1:0] tapChan,
  input wire logic [COEF_ADDR_W-1:0] tapIdx,
  output logic coefValid,
  output logic [COEF_ADDR_W-1:0] coefAddr,
  input wire logic resValid,
  input wire logic [1:0] resChan,
  input wire logic signed [IN_W-1:0] resData,
  input wire logic [7:0] tagLow,
  output logic outValid,
  output logic [1:0] outChan,
  output logic [rsc_pkg::OUT_W-1:0] outData,
  output logic [1:0] outputChannelCode,
  output logic [1:0] filterCountCode,
  output logic [5:0] multiplyCountCode,
  output logic asymmetricFilterFlag,
  output logic symmetricFilter,
  output logic [7:0] channelRouting,
  output logic [7:0] channelSumming,
  output logic [7:0] resamplerClockDivider,
  output logic [7:0] ratioAssignment
);

  // ********************************************************************
  // Reset release
  // ********************************************************************
  logic rstMeta_ff;
  logic rstSync_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_n <= rstMeta_ff;
    end
  end

  // ********************************************************************
  // Register storage
  // ********************************************************************
  localparam logic [7:0] RESET_VALUES [rsc_pkg::NUM_REGS] = '{
    rsc_pkg::RST_OUT_CHAN_CFG, rsc_pkg::RST_MULT_CNT_CFG,
    rsc_pkg::RST_FILTER_ASSIGN, rsc_pkg::RST_GAIN_ROUND,
    rsc_pkg::RST_CHAN_ROUTING, rsc_pkg::RST_CHAN_SUMMING,
    rsc_pkg::RST_CLK_DIVIDER, rsc_pkg::RST_RATIO_ASSIGN
  };

  logic [7:0] regFile_ff [rsc_pkg::NUM_REGS];

  // True when a word index falls on one of the eight live registers.
  function automatic logic is_live(input logic [5:0] idx);
    return (idx >= rsc_pkg::IDX_OUT_CHAN_CFG) && (idx <= rsc_pkg::IDX_RATIO_ASSIGN);
  endfunction : is_live

  // Slot within the register file for a live index.
  function automatic logic [2:0] slot_of(input logic [5:0] idx);
    return idx[2:0];
  endfunction : slot_of

  // ********************************************************************
  // AHB-Lite address phase
  // ********************************************************************
  logic addrTaken;
  logic [5:0] addrIdx;
  logic addrInPage;
  logic wrPend_ff;
  logic [5:0] wrIdx_ff;

  always_comb begin
    addrTaken = hsel && hready && htrans[1];
    addrIdx = haddr[7:2];
    addrInPage = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 6'h00;
    end else begin
      wrPend_ff <= addrTaken && hwrite && addrInPage && is_live(addrIdx);
      if (addrTaken) begin
        wrIdx_ff <= addrIdx;
      end
    end
  end

  // ********************************************************************
  // AHB-Lite data phase: writes
  // ********************************************************************
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      for (int i = 0; i < rsc_pkg::NUM_REGS; i++) begin
        regFile_ff[i] <= RESET_VALUES[i];
      end
    end else if (wrPend_ff) begin
      regFile_ff[slot_of(wrIdx_ff)] <= hwdata[7:0];
    end
  end

  // ********************************************************************
  // AHB-Lite read data
  // ********************************************************************
  logic [7:0] nxt_readByte;

  always_comb begin
    nxt_readByte = 8'h00;
    if (addrInPage && is_live(addrIdx)) begin
      nxt_readByte = regFile_ff[slot_of(addrIdx)];
      // A write still in its data phase to the same word is forwarded.
      if (wrPend_ff && (wrIdx_ff == addrIdx)) begin
        nxt_readByte = hwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hrdata <= 32'h00000000;
    end else if (addrTaken && !hwrite) begin
      hrdata <= {24'h000000, nxt_readByte};
    end
  end

  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
  end

  // ********************************************************************
  // Configuration fields
  // ********************************************************************
  logic [7:0] outChanCfg;
  logic [7:0] multCntCfg;
  logic [7:0] filterAssign;
  logic [7:0] gainRound;
  logic [2:0] resamplerSyncSelect;

  always_comb begin
    outChanCfg = regFile_ff[slot_of(rsc_pkg::IDX_OUT_CHAN_CFG)];
    multCntCfg = regFile_ff[slot_of(rsc_pkg::IDX_MULT_CNT_CFG)];
    filterAssign = regFile_ff[slot_of(rsc_pkg::IDX_FILTER_ASSIGN)];
    gainRound = regFile_ff[slot_of(rsc_pkg::IDX_GAIN_ROUND)];
    outputChannelCode = outChanCfg[rsc_pkg::OCC_CHAN_LSB +: 2];
    filterCountCode = outChanCfg[rsc_pkg::OCC_FILT_LSB +: 2];
    resamplerSyncSelect = outChanCfg[rsc_pkg::OCC_SYNC_LSB +: 3];
    multiplyCountCode = multCntCfg[rsc_pkg::MCC_COUNT_LSB +: 6];
    asymmetricFilterFlag = multCntCfg[rsc_pkg::MCC_ASYM_BIT];
    symmetricFilter = !asymmetricFilterFlag;
    channelRouting = regFile_ff[slot_of(rsc_pkg::IDX_CHAN_ROUTING)];
    channelSumming = regFile_ff[slot_of(rsc_pkg::IDX_CHAN_SUMMING)];
    resamplerClockDivider = regFile_ff[slot_of(rsc_pkg::IDX_CLK_DIVIDER)];
    ratioAssignment = regFile_ff[slot_of(rsc_pkg::IDX_RATIO_ASSIGN)];
  end

  // ********************************************************************
  // Sync-driven clear of the delay accumulators
  // ********************************************************************
  logic [DLY_W-1:0] delayAcc_ff [4];

  always_comb begin
    syncClear = syncSources[resamplerSyncSelect];
    for (int c = 0; c < 4; c++) begin
      delayAccum[c*DLY_W +: DLY_W] = delayAcc_ff[c];
    end
  end

  // The clear reaches all four channels on the same edge and wins over an advance.
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      for (int c = 0; c < 4; c++) begin
        delayAcc_ff[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (syncClear) begin
          delayAcc_ff[c] <= '0;
        end else if (dlyAdvance[c]) begin
          delayAcc_ff[c] <= delayAcc_ff[c] + dlyStep;
        end
      end
    end
  end

  // ********************************************************************
  // Coefficient addressing
  // ********************************************************************
  rsc_coef_mapper #(
    .ADDR_W(COEF_ADDR_W)
  ) uCoefMapper (
    .core_clk(core_clk),
    .rstSync_n(rstSync_n),
    .tapReq(tapReq),
    .tapChan(tapChan),
    .tapIdx(tapIdx),
    .filterCountCode(filterCountCode),
    .filterSelect(filterAssign),
    .coefValid(coefValid),
    .coefAddr(coefAddr)
  );

  // ********************************************************************
  // Output shaping
  // ********************************************************************
  rsc_output_shaper #(
    .IN_W(IN_W)
  ) uOutputShaper (
    .core_clk(core_clk),
    .rstSync_n(rstSync_n),
    .inValid(resValid),
    .inChan(resChan),
    .inData(resData),
    .gainShift(gainRound[rsc_pkg::GSR_SHIFT_LSB +: 4]),
    .roundCode(gainRound[rsc_pkg::GSR_ROUND_LSB +: 2]),
    .tagMode(gainRound[rsc_pkg::GSR_TAG_BIT]),
    .tagLow(tagLow),
    .outValid(outValid),
    .outChan(outChan),
    .outData(outData)
  );

endmodule : rsc_resampler_ctrl

// ---- testbench/rsc_resampler_ctrl_monitor.sv ----
/*
  Checker for the resampler control block, bound to its top module.
  Assumes one clock domain on core_clk, with rst_n as its reset.
*/
`timescale 1ns/1ns
module rsc_resampler_ctrl_monitor #(
  parameter int IN_W = 32,
  parameter int DLY_W = 16,
  parameter int COEF_ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [4*DLY_W-1:0] delayAccum,
  input wire logic syncClear,
  input wire logic tapReq,
  input wire logic [COEF_ADDR_W-1:0] tapIdx,
  input wire logic coefValid,
  input wire logic [COEF_ADDR_W-1:0] coefAddr,
  input wire logic resValid,
  input wire logic [1:0] resChan,
  input wire logic outValid,
  input wire logic [1:0] outChan,
  input wire logic [rsc_pkg::OUT_W-1:0] outData,
  input wire logic [1:0] filterCountCode,
  input wire logic asymmetricFilterFlag,
  input wire logic symmetricFilter
);
  // ********************************************************************
  // Properties
  // ********************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_sym_flag: assert property (symmetricFilter == !asymmetricFilterFlag)
    else $error("symmetry level disagrees with flag");
  a_sync_clear: assert property (syncClear |=> delayAccum == '0)
    else $error("accumulators not cleared after sync");
  a_coef_pulse: assert property (coefValid == $past(tapReq))
    else $error("coefficient valid not one cycle after request");
  a_coef_single: assert property (tapReq && filterCountCode == 2'h0 |=> coefAddr == $past(tapIdx))
    else $error("single filter address not tap index");
  a_out_pulse: assert property (resValid |=> outValid && outChan == $past(resChan))
    else $error("result not delivered one cycle later");
  a_out_hold: assert property (!outValid |-> $stable(outData))
    else $error("output word changed without valid");
  a_nf_by_write: assert property ($changed(filterCountCode) |->
    $past(hsel && hready && htrans[1] && hwrite && haddr[7:2] == rsc_pkg::IDX_OUT_CHAN_CFG, 2))
    else $error("filter count changed without a write");
endmodule : rsc_resampler_ctrl_monitor

bind rsc_resampler_ctrl rsc_resampler_ctrl_monitor #(.IN_W(IN_W), .DLY_W(DLY_W), .COEF_ADDR_W(COEF_ADDR_W)) u_mon (
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .delayAccum(delayAccum),
  .syncClear(syncClear), .tapReq(tapReq), .tapIdx(tapIdx), .coefValid(coefValid), .coefAddr(coefAddr),
  .resValid(resValid), .resChan(resChan), .outValid(outValid), .outChan(outChan), .outData(outData),
  .filterCountCode(filterCountCode), .asymmetricFilterFlag(asymmetricFilterFlag),
  .symmetricFilter(symmetricFilter));

// ---- testbench/rsc_resampler_ctrl_tb.sv ----
/*
  Self-checking testbench for the resampler control block.
  Assumes the design package and the bound checker are compiled beforehand.
*/
`timescale 1ns/1ns
module rsc_resampler_ctrl_tb;
  logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, tapReq, resValid;
  logic [31:0] haddr, hwdata, hrdata, r, resData;
  logic [1:0] htrans, tapChan, resChan, outChan, sel;
  logic [2:0] hsize;
  logic [7:0] syncSources, tapIdx, tagLow, coefAddr, expA;
  logic [3:0] dlyAdvance;
  logic [15:0] dlyStep;
  logic [63:0] delayAccum;
  logic syncClear, coefValid, outValid, asymFlag, symFilter;
  logic [23:0] outData;
  logic [1:0] ocCode, fcCode;
  logic [5:0] mcCode;
  logic [7:0] routing, summing, clkDiv, ratio;
  int errorCnt, checks, i, c, t, k;
  logic [7:0] rstv [8] = '{rsc_pkg::RST_OUT_CHAN_CFG, rsc_pkg::RST_MULT_CNT_CFG, rsc_pkg::RST_FILTER_ASSIGN,
    rsc_pkg::RST_GAIN_ROUND, rsc_pkg::RST_CHAN_ROUTING, rsc_pkg::RST_CHAN_SUMMING, rsc_pkg::RST_CLK_DIVIDER,
    rsc_pkg::RST_RATIO_ASSIGN};
  logic [7:0] wv [8] = '{8'h31, 8'h45, 8'h1b, 8'h27, 8'h1b, 8'h07, 8'h05, 8'h93};
  logic [1:0] nfv [3] = '{2'h0, 2'h1, 2'h3};
  logic [7:0] fsv [3] = '{8'h00, 8'h44, 8'hb4};
  logic [31:0] dv [2] = '{32'h00123456, 32'hfff98765};

  rsc_resampler_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .syncSources(syncSources), .dlyAdvance(dlyAdvance), .dlyStep(dlyStep),
    .delayAccum(delayAccum), .syncClear(syncClear), .tapReq(tapReq), .tapChan(tapChan), .tapIdx(tapIdx),
    .coefValid(coefValid), .coefAddr(coefAddr), .resValid(resValid), .resChan(resChan), .resData(resData),
    .tagLow(tagLow), .outValid(outValid), .outChan(outChan), .outData(outData), .outputChannelCode(ocCode),
    .filterCountCode(fcCode), .multiplyCountCode(mcCode), .asymmetricFilterFlag(asymFlag),
    .symmetricFilter(symFilter), .channelRouting(routing), .channelSumming(summing),
    .resamplerClockDivider(clkDiv), .ratioAssignment(ratio));

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] x;
    ahb(1'b1, idx, wd, x);
  endtask : wr

  task results();
    if (errorCnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Expected shaper word: shift, keep the top bits, round, then tag.
  function automatic logic [23:0] shp(logic [31:0] d, logic [3:0] sh, logic [1:0] rc, logic tg, logic [1:0] tb);
    logic [31:0] s;
    logic [24:0] w;
    int kb;
    s = d << sh;
    w = s[31:7];
    kb = (rc == 2'h3) ? (tg ? 22 : 24) : 12 + 4 * rc;
    w = w + (25'h1 << (24 - kb));
    shp = w[24:1];
    if (tg) shp[1:0] = tb;
  endfunction : shp

  // ********************************************************************
  // Clock, watchdog and tests
  // ********************************************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    #300000;
    errorCnt++;
    results();
  end

  initial begin
    {hsel, hwrite, tapReq, resValid, htrans, tapChan, resChan} = '0;
    {haddr, hwdata, resData, syncSources, tapIdx} = '0;
    hsize = 3'h2;
    dlyAdvance = 4'hf;
    dlyStep = 16'h0001;
    tagLow = 8'h9c;
    rst_n = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 8; i++) begin
      ahb(1'b0, 6'h10 + 6'(i), 8'h0, r);
      chk(r, {24'h0, rstv[i]});
    end
    wr(6'h18, 8'hff);
    ahb(1'b0, 6'h18, 8'h0, r);
    chk(r, 32'h0);
    ahb(1'b0, 6'h1f, 8'h0, r);
    chk(r, 32'h0);
    for (i = 0; i < 8; i++) wr(6'h10 + 6'(i), wv[i]);
    for (i = 0; i < 8; i++) begin
      ahb(1'b0, 6'h10 + 6'(i), 8'h0, r);
      chk(r, {24'h0, wv[i]});
    end
    #1;
    chk({ocCode, fcCode, mcCode, asymFlag, symFilter}, 32'h416);
    chk({routing, summing, clkDiv, ratio}, 32'h1b070593);
    wr(6'h10, 8'h00);
    wr(6'h11, 8'h06);
    #1 chk({mcCode, asymFlag, symFilter}, 32'h19);
    for (i = 0; i < 8; i++) begin
      wr(6'h10, {1'b0, 3'(i), 4'h3});
      @(posedge core_clk);
      syncSources <= ~(8'h01 << i);
      @(posedge core_clk);
      #1 chk({syncClear, delayAccum != '0}, 32'h1);
      @(posedge core_clk);
      syncSources <= 8'h01 << i;
      #1 chk(syncClear, 1);
      @(posedge core_clk);
      syncSources <= 8'h00;
      #1 chk(delayAccum == '0, 1);
    end
    for (i = 0; i < 3; i++) begin
      wr(6'h10, {4'h0, nfv[i], 2'h3});
      wr(6'h12, fsv[i]);
      for (c = 0; c < 4; c++) begin
        @(posedge core_clk);
        tapReq <= 1'b1;
        tapChan <= 2'(c);
        tapIdx <= 8'ha5;
        @(posedge core_clk);
        tapReq <= 1'b0;
        sel = fsv[i][2*c+:2];
        expA = (nfv[i] == 2'h0) ? 8'ha5 : (nfv[i] == 2'h1) ? {7'h25, sel[0]} : {6'h25, sel};
        #1 chk({coefValid, coefAddr}, {23'h1, expA});
      end
    end
    for (t = 0; t < 2; t++)
      for (c = 0; c < 4; c++)
        for (k = 0; k < 2; k++) begin
          wr(6'h13, {1'b0, 1'(t), 2'(c), 4'(c * 5)});
          @(posedge core_clk);
          resValid <= 1'b1;
          resChan <= 2'(c);
          resData <= dv[k];
          @(posedge core_clk);
          resValid <= 1'b0;
          #1 chk({outValid, outChan}, 4 + c);
          chk(outData, shp(dv[k], 4'(c * 5), 2'(c), 1'(t), tagLow[2*c+:2]));
        end
    results();
  end
endmodule : rsc_resampler_ctrl_tb
